// ---- pkg/rcbm_pkg.sv ----
// Purpose: constants and carrier types for reset configuration and base map
// Assumes: 32-bit byte address space
// Notes:   one package shared by both design files
package rcbm_pkg;

  typedef enum {OPM_MASTER, OPM_SINGLE, OPM_FACTORY, OPM_RESERVED} rcbm_opmode_t;
  typedef enum {CLK_PLL_XTAL, CLK_PLL_EXT, CLK_PLL_1TO1, CLK_BYPASS} rcbm_clkmode_t;
  typedef enum {SP_NONE, SP_FLASH, SP_SRAM, SP_PERIPH, SP_BACKDOOR, SP_EXTERNAL} rcbm_space_t;

  localparam logic [2:0] OPM_CODE_MASTER  = 3'h7;
  localparam logic [2:0] OPM_CODE_SINGLE  = 3'h6;
  localparam logic [2:0] OPM_CODE_FACTORY = 3'h4;
  localparam logic [1:0] BOOT_CODE_INT32  = 2'h0;
  localparam logic [1:0] BOOT_CODE_EXT8   = 2'h2;
  localparam logic [1:0] BOOT_CODE_EXT16  = 2'h1;
  localparam logic [1:0] CLK_CODE_XTAL    = 2'h3;
  localparam logic [1:0] CLK_CODE_EXT     = 2'h2;
  localparam logic [1:0] CLK_CODE_1TO1    = 2'h1;
  localparam logic [1:0] PIN_CODE_ADDR    = 2'h0;
  localparam logic [1:0] PIN_CODE_CS6     = 2'h2;
  localparam logic [1:0] PIN_CODE_CS65    = 2'h1;

  localparam logic [1:0] WIDTH_8          = 2'h0;
  localparam logic [1:0] WIDTH_16         = 2'h1;
  localparam logic [1:0] WIDTH_32         = 2'h2;

  localparam int         MEM_ALIGN_BITS   = 15;
  localparam int         PER_ALIGN_BITS   = 30;
  localparam logic [31:0] FLASH_BASE_RST  = 32'h0000_0000;
  localparam logic [31:0] SRAM_BASE_RST   = 32'h0000_0000;
  localparam logic [31:0] PER_BASE_RST    = 32'h4000_0000;
  localparam logic [31:0] BACKDOOR_OFS    = 32'h0400_0000;

  typedef struct packed {
    rcbm_opmode_t  opmode;
    logic          boot_ext;
    logic [1:0]    boot_width;
    logic          drive_full;
    rcbm_clkmode_t clkmode;
    logic [2:0]    cs_sel;
  } rcbm_cfg_t;

  typedef struct packed {
    logic [31:0] base;
    logic        valid;
  } rcbm_bar_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    logic        core;
    logic        write;
  } rcbm_req_t;

endpackage : rcbm_pkg

// ---- hdl/rcbm_decoder.sv ----
// Purpose: address decoder against the programmed base registers
// Assumes: same clock as the caller
// Notes:   registered result, one cycle after the request
`timescale 1ns/1ps
`default_nettype none
module rcbm_decoder
  import rcbm_pkg::*;
#(
  parameter int FLASH_BITS = 19,
  parameter int SRAM_BITS  = 16
) (
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  input  wire rcbm_req_t   req_in,
  input  wire rcbm_bar_t   flash_bar_in,
  input  wire rcbm_bar_t   sram_bar_in,
  input  wire rcbm_bar_t   per_bar_in,
  input  wire logic [3:0]  ext_hit_in,
  output rcbm_space_t      space_out,
  output logic [31:0]      offset_out,
  output logic             hit_valid_out
);

  initial begin
    if (FLASH_BITS < MEM_ALIGN_BITS || FLASH_BITS > PER_ALIGN_BITS) $error("FLASH_BITS out of range");
    if (SRAM_BITS < MEM_ALIGN_BITS || SRAM_BITS > PER_ALIGN_BITS) $error("SRAM_BITS out of range");
  end

  typedef struct packed {
    rcbm_space_t space;
    logic [31:0] offset;
    logic        hv;
  } rcbm_dec_st_t;

  rcbm_dec_st_t st_ff;
  rcbm_dec_st_t nxt_st;
  logic         hit_fl;
  logic         hit_sr;
  logic         hit_pe;
  logic         hit_bd;
  logic [31:0]  bd_base;

  assign bd_base = per_bar_in.base + BACKDOOR_OFS;
  assign hit_fl = flash_bar_in.valid && req_in.core && !req_in.write &&
                  (req_in.addr[31:FLASH_BITS] == flash_bar_in.base[31:FLASH_BITS]);
  assign hit_sr = sram_bar_in.valid &&
                  (req_in.addr[31:SRAM_BITS] == sram_bar_in.base[31:SRAM_BITS]);
  assign hit_pe = per_bar_in.valid &&
                  (req_in.addr[31:PER_ALIGN_BITS] == per_bar_in.base[31:PER_ALIGN_BITS]);
  assign hit_bd = per_bar_in.valid &&
                  (req_in.addr[31:FLASH_BITS] == bd_base[31:FLASH_BITS]);

  always_comb begin
    nxt_st        = st_ff;
    nxt_st.hv     = req_in.valid;
    nxt_st.space  = SP_NONE;
    nxt_st.offset = 32'h0000_0000;
    if (!req_in.valid) begin
      nxt_st.space = SP_NONE;
    end else if (hit_sr) begin
      nxt_st.space  = SP_SRAM;
      nxt_st.offset = req_in.addr - sram_bar_in.base;
    end else if (hit_fl) begin
      nxt_st.space  = SP_FLASH;
      nxt_st.offset = req_in.addr - flash_bar_in.base;
    end else if (hit_bd) begin
      nxt_st.space  = SP_BACKDOOR;
      nxt_st.offset = req_in.addr - bd_base;
    end else if (hit_pe) begin
      nxt_st.space  = SP_PERIPH;
      nxt_st.offset = req_in.addr - per_bar_in.base;
    end else if (|ext_hit_in) begin
      nxt_st.space  = SP_EXTERNAL;
      nxt_st.offset = req_in.addr;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      st_ff <= '{space: SP_NONE, offset: 32'h0000_0000, hv: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign space_out     = st_ff.space;
  assign offset_out    = st_ff.offset;
  assign hit_valid_out = st_ff.hv;

  sram_prio_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    req_in.valid && hit_sr |=> space_out == SP_SRAM) else $error("sram not chosen");
  invalid_bar_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    req_in.valid && !flash_bar_in.valid |=> space_out != SP_FLASH)
    else $error("flash hit while invalid");

endmodule : rcbm_decoder
`default_nettype wire

// ---- hdl/rcbm_top.sv ----
// Purpose: reset-time configuration capture and base map registers
// Assumes: pins held stable by board latch while reset is high
// Notes:   pins pass two flops; capture on reset release
`timescale 1ns/1ps
`default_nettype none
module rcbm_top
  import rcbm_pkg::*;
#(
  parameter int FLASH_BITS = 19,
  parameter int SRAM_BITS  = 16
) (
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  input  wire logic        config_sample_enable_n_in,
  input  wire logic [2:0]  opmode_cfg_pins_in,
  input  wire logic [1:0]  boot_cfg_pins_in,
  input  wire logic        drive_strength_cfg_pin_in,
  input  wire logic        clock_select_hi_pin_in,
  input  wire logic        clock_select_lo_pin_in,
  input  wire logic [1:0]  shared_pin_use_cfg_pins_in,
  input  wire logic        flash_bar_wr_in,
  input  wire logic        sram_bar_wr_in,
  input  wire logic        per_bar_wr_in,
  input  wire rcbm_bar_t   bar_wdata_in,
  input  wire rcbm_req_t   req_in,
  input  wire logic [3:0]  ext_hit_in,
  output rcbm_cfg_t        cfg_out,
  output logic             cfg_done_out,
  output logic [2:0]       shared_is_cs_out,
  output rcbm_bar_t        flash_base_reg_out,
  output rcbm_bar_t        sram_base_reg_out,
  output rcbm_bar_t        peripheral_base_reg_out,
  output logic             bar_reject_out,
  output rcbm_space_t      space_out,
  output logic [31:0]      offset_out,
  output logic             hit_valid_out
);

  initial begin
    if (FLASH_BITS < MEM_ALIGN_BITS) $error("FLASH_BITS too small");
  end

  typedef struct packed {
    logic [10:0] p1;
    logic [10:0] p2;
    logic       in_rst;
    logic       done;
    rcbm_cfg_t  cfg;
    logic [2:0] cs;
    rcbm_bar_t  fbar;
    rcbm_bar_t  sbar;
    rcbm_bar_t  pbar;
    logic       rej;
  } rcbm_st_t;

  rcbm_st_t   st_ff;
  rcbm_st_t   nxt_st;
  logic [10:0] pins_raw;
  rcbm_cfg_t  smp;
  logic [2:0] smp_cs;
  logic [2:0] opm;
  logic [1:0] bt;
  logic [1:0] ck;
  logic [1:0] sp;

  localparam rcbm_cfg_t CFG_DEFAULT = '{opmode: OPM_SINGLE, boot_ext: 1'b0,
    boot_width: WIDTH_32, drive_full: 1'b0, clkmode: CLK_PLL_XTAL, cs_sel: 3'h0};

  assign pins_raw = {config_sample_enable_n_in, opmode_cfg_pins_in, boot_cfg_pins_in,
                     drive_strength_cfg_pin_in, clock_select_hi_pin_in,
                     clock_select_lo_pin_in, shared_pin_use_cfg_pins_in};
  assign opm = st_ff.p2[9:7];
  assign bt  = st_ff.p2[6:5];
  assign ck  = st_ff.p2[3:2];
  assign sp  = st_ff.p2[1:0];

  always_comb begin
    smp = CFG_DEFAULT;
    if (opm == OPM_CODE_MASTER) begin
      smp.opmode = OPM_MASTER;
    end else if (opm == OPM_CODE_SINGLE) begin
      smp.opmode = OPM_SINGLE;
    end else if (opm == OPM_CODE_FACTORY) begin
      smp.opmode = OPM_FACTORY;
    end else begin
      smp.opmode = OPM_RESERVED;
    end
    smp.boot_ext = (bt != BOOT_CODE_INT32);
    if (bt == BOOT_CODE_EXT8) begin
      smp.boot_width = WIDTH_8;
    end else if (bt == BOOT_CODE_EXT16) begin
      smp.boot_width = WIDTH_16;
    end else begin
      smp.boot_width = WIDTH_32;
    end
    if (smp.opmode == OPM_SINGLE) begin
      smp.boot_width = WIDTH_32;
    end
    smp.drive_full = st_ff.p2[4];
    if (ck == CLK_CODE_XTAL) begin
      smp.clkmode = CLK_PLL_XTAL;
    end else if (ck == CLK_CODE_EXT) begin
      smp.clkmode = CLK_PLL_EXT;
    end else if (ck == CLK_CODE_1TO1) begin
      smp.clkmode = CLK_PLL_1TO1;
    end else begin
      smp.clkmode = CLK_BYPASS;
    end
    if (sp == PIN_CODE_ADDR) begin
      smp_cs = 3'h0;
    end else if (sp == PIN_CODE_CS6) begin
      smp_cs = 3'h4;
    end else if (sp == PIN_CODE_CS65) begin
      smp_cs = 3'h6;
    end else begin
      smp_cs = 3'h7;
    end
    smp.cs_sel = smp_cs;
  end

  always_comb begin
    nxt_st        = st_ff;
    nxt_st.p1     = pins_raw;
    nxt_st.p2     = st_ff.p1;
    nxt_st.in_rst = 1'b0;
    nxt_st.rej    = 1'b0;
    if (st_ff.in_rst && !st_ff.done) begin
      nxt_st.done = 1'b1;
      if (!st_ff.p2[10]) begin
        nxt_st.cfg = smp;
        nxt_st.cs  = smp.cs_sel;
      end else begin
        nxt_st.cfg = CFG_DEFAULT;
        nxt_st.cs  = 3'h0;
      end
      nxt_st.fbar.base  = FLASH_BASE_RST;
      nxt_st.fbar.valid = !st_ff.p2[10] ? (bt == BOOT_CODE_INT32) : 1'b1;
    end
    if (flash_bar_wr_in) begin
      if (|bar_wdata_in.base[MEM_ALIGN_BITS-1:0]) begin
        nxt_st.rej = 1'b1;
      end else begin
        nxt_st.fbar = bar_wdata_in;
      end
    end else if (sram_bar_wr_in) begin
      if (|bar_wdata_in.base[MEM_ALIGN_BITS-1:0]) begin
        nxt_st.rej = 1'b1;
      end else begin
        nxt_st.sbar = bar_wdata_in;
      end
    end else if (per_bar_wr_in) begin
      if (|bar_wdata_in.base[PER_ALIGN_BITS-1:0]) begin
        nxt_st.rej = 1'b1;
      end else begin
        nxt_st.pbar = bar_wdata_in;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      // Synchroniser keeps filling so release sees reset-time pins
      st_ff.p1     <= pins_raw;
      st_ff.p2     <= st_ff.p1;
      st_ff.in_rst <= 1'b1;
      st_ff.done   <= 1'b0;
      st_ff.cfg    <= CFG_DEFAULT;
      st_ff.cs     <= 3'h0;
      st_ff.fbar   <= '{base: FLASH_BASE_RST, valid: 1'b0};
      st_ff.sbar   <= '{base: SRAM_BASE_RST, valid: 1'b0};
      st_ff.pbar   <= '{base: PER_BASE_RST, valid: 1'b1};
      st_ff.rej    <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign cfg_out                 = st_ff.cfg;
  assign cfg_done_out            = st_ff.done;
  assign shared_is_cs_out        = st_ff.cs;
  assign flash_base_reg_out      = st_ff.fbar;
  assign sram_base_reg_out       = st_ff.sbar;
  assign peripheral_base_reg_out = st_ff.pbar;
  assign bar_reject_out          = st_ff.rej;

  rcbm_decoder #(
    .FLASH_BITS (FLASH_BITS),
    .SRAM_BITS  (SRAM_BITS)
  ) u_dec (
    .sys_clk_in    (sys_clk_in),
    .rst_in        (rst_in),
    .req_in        (req_in),
    .flash_bar_in  (st_ff.fbar),
    .sram_bar_in   (st_ff.sbar),
    .per_bar_in    (st_ff.pbar),
    .ext_hit_in    (ext_hit_in),
    .space_out     (space_out),
    .offset_out    (offset_out),
    .hit_valid_out (hit_valid_out)
  );

  cfg_hold_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    cfg_done_out && $past(cfg_done_out) |-> $stable(cfg_out)) else $error("cfg changed");
  single_w32_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    cfg_out.opmode == OPM_SINGLE |-> cfg_out.boot_width == WIDTH_32)
    else $error("single-chip width");
  fbar_align_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    flash_base_reg_out.base[MEM_ALIGN_BITS-1:0] == '0) else $error("flash unaligned");
  sbar_align_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    sram_base_reg_out.base[MEM_ALIGN_BITS-1:0] == '0) else $error("sram unaligned");
  pbar_align_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    peripheral_base_reg_out.base[PER_ALIGN_BITS-1:0] == '0) else $error("per unaligned");
  per_reset_a: assert property (@(posedge sys_clk_in)
    $fell(rst_in) |-> peripheral_base_reg_out.valid && !cfg_done_out)
    else $error("per not valid");
  default_cfg_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    $rose(cfg_done_out) && $past(st_ff.p2[10]) |-> cfg_out == CFG_DEFAULT)
    else $error("defaults wrong");
  cs_map_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
    shared_is_cs_out inside {3'h0, 3'h4, 3'h6, 3'h7}) else $error("cs map");

  cov_sampled_c: cover property (@(posedge sys_clk_in) $rose(cfg_done_out) && !$past(st_ff.p2[10]));
  cov_reject_c: cover property (@(posedge sys_clk_in) bar_reject_out);
  cov_backdoor_c: cover property (@(posedge sys_clk_in) space_out == SP_BACKDOOR);

endmodule : rcbm_top
`default_nettype wire

// ---- dv/rcbm_cfg_latch.sv ----
// Purpose: board latch model driving the reset configuration pins
// Assumes: the bench reset that also drives the device reset input gates the latch
// Notes:   pins toggle every cycle once the latch lets go
`timescale 1ns/1ps
`default_nettype none
module rcbm_cfg_latch (
  input  wire logic       sys_clk_in,
  input  wire logic       rst_in,
  input  wire logic [9:0] want_in,
  output logic      [9:0] pins_out
);
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      pins_out <= want_in;
    end else begin
      pins_out <= ~pins_out;
    end
  end
endmodule : rcbm_cfg_latch
`default_nettype wire

// ---- dv/rcbm_top_test.sv ----
// Purpose: self-checking bench for configuration capture and base map
// Assumes: latch model supplies the configuration pins
// Notes:   one task per scenario, checks inside each task
`timescale 1ns/1ps
`default_nettype none
module rcbm_top_test;
  import rcbm_pkg::*;
  logic        clk;
  logic        rst;
  logic        en_n;
  logic [9:0]  want;
  logic [9:0]  pins;
  logic [2:0]  bwr;
  rcbm_bar_t   bdata;
  rcbm_req_t   req;
  logic [3:0]  ext_hit;
  rcbm_cfg_t   cfg;
  logic        done;
  logic [2:0]  is_cs;
  rcbm_bar_t   fbar;
  rcbm_bar_t   sbar;
  rcbm_bar_t   pbar;
  logic        rej;
  rcbm_space_t space;
  logic [31:0] ofs;
  logic        hv;
  int          mismatches;
  int          n_tests;
  int          cycles;

  rcbm_cfg_latch rcbm_cfg_latch_i (.sys_clk_in(clk), .rst_in(rst), .want_in(want),
    .pins_out(pins));
  rcbm_top rcbm_top_i (.sys_clk_in(clk), .rst_in(rst), .config_sample_enable_n_in(en_n),
    .opmode_cfg_pins_in(pins[9:7]), .boot_cfg_pins_in(pins[6:5]),
    .drive_strength_cfg_pin_in(pins[4]), .clock_select_hi_pin_in(pins[3]),
    .clock_select_lo_pin_in(pins[2]), .shared_pin_use_cfg_pins_in(pins[1:0]),
    .flash_bar_wr_in(bwr[0]), .sram_bar_wr_in(bwr[1]), .per_bar_wr_in(bwr[2]),
    .bar_wdata_in(bdata), .req_in(req), .ext_hit_in(ext_hit), .cfg_out(cfg),
    .cfg_done_out(done), .shared_is_cs_out(is_cs), .flash_base_reg_out(fbar),
    .sram_base_reg_out(sbar), .peripheral_base_reg_out(pbar), .bar_reject_out(rej),
    .space_out(space), .offset_out(ofs), .hit_valid_out(hv));

  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end

  task automatic tally_and_finish;
    $display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      mismatches++;
      tally_and_finish();
    end
  end

  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Reset with given enable and pins, then check capture twice
  task automatic cfg_case(logic e, logic [9:0] w, rcbm_opmode_t o, logic [1:0] ext,
    logic [1:0] wid, logic drv, rcbm_clkmode_t ck, logic [2:0] cs);
    @(posedge clk);
    rst  <= 1'h1;
    en_n <= e;
    want <= w;
    repeat (8) @(posedge clk);
    rst <= 1'h0;
    for (int p = 0; p < 2; p++) begin
      repeat (3) @(posedge clk);
      #1;
      chk(32'(done), 32'h1);
      chk(32'(cfg.opmode), 32'(o));
      chk(32'(cfg.boot_width), 32'(wid));
      chk(32'(cfg.drive_full), 32'(drv));
      chk(32'(cfg.clkmode), 32'(ck));
      chk(32'(is_cs), 32'(cs));
      chk(32'(cfg.cs_sel), 32'(cs));
      if (ext != 2'h2) begin
        chk(32'(cfg.boot_ext), 32'(ext[0]));
        chk(32'(fbar.valid), 32'(!ext[0]));
      end
    end
  endtask : cfg_case

  // Base register write, then reject pulse and register contents
  task automatic bw(int sel, logic [31:0] b, logic r, logic [31:0] exp_b);
    rcbm_bar_t got;
    @(posedge clk);
    bwr[sel] <= 1'h1;
    bdata    <= '{base: b, valid: 1'h1};
    @(posedge clk);
    bwr <= 3'h0;
    #1;
    chk(32'(rej), 32'(r));
    @(posedge clk);
    #1;
    got = (sel == 0) ? fbar : (sel == 1) ? sbar : pbar;
    chk(got.base, exp_b);
  endtask : bw

  // Decode one request, a read unless wr is set
  task automatic dec(logic [31:0] a, logic core, logic [3:0] eh, rcbm_space_t sp,
    logic [31:0] o, logic ck_o, logic wr = 1'h0);
    @(posedge clk);
    req     <= '{valid: 1'h1, addr: a, core: core, write: wr};
    ext_hit <= eh;
    @(posedge clk);
    #1;
    chk(32'(space), 32'(sp));
    chk(32'(hv), 32'h1);
    if (ck_o) begin
      chk(ofs, o);
    end
  endtask : dec

  task automatic defaults_and_map;
    cfg_case(1'h1, 10'h3D3, OPM_SINGLE, 2'h0, WIDTH_32, 1'h0, CLK_PLL_XTAL, 3'h0);
    chk(fbar.base, FLASH_BASE_RST);
    chk(32'(sbar.valid), 32'h0);
    chk(pbar.base, 32'h4000_0000);
    chk(32'(pbar.valid), 32'h1);
    dec(32'h0000_0010, 1'h1, 4'h0, SP_FLASH, 32'h10, 1'h1);
    dec(32'h0000_0010, 1'h0, 4'h0, SP_NONE, 32'h0, 1'h0);
    dec(32'h0000_0010, 1'h1, 4'h0, SP_NONE, 32'h0, 1'h0, 1'h1);
    dec(32'h4400_0020, 1'h0, 4'h0, SP_BACKDOOR, 32'h20, 1'h1);
    dec(32'h4000_0100, 1'h1, 4'h0, SP_PERIPH, 32'h100, 1'h1);
    dec(32'h2000_0000, 1'h1, 4'h1, SP_EXTERNAL, 32'h2000_0000, 1'h1);
    bw(1, 32'h0000_4000, 1'h1, 32'h0000_0000);
    dec(32'h0000_0010, 1'h1, 4'h0, SP_FLASH, 32'h10, 1'h1);
    bw(1, 32'h0000_0000, 1'h0, 32'h0000_0000);
    dec(32'h0000_0010, 1'h1, 4'h0, SP_SRAM, 32'h10, 1'h1);
    bw(0, 32'h0001_4000, 1'h1, 32'h0000_0000);
    bw(0, 32'h0008_8000, 1'h0, 32'h0008_8000);
    dec(32'h0008_8004, 1'h1, 4'h0, SP_FLASH, 32'h4, 1'h1);
    bw(2, 32'h1000_0000, 1'h1, 32'h4000_0000);
    bw(2, 32'hC000_0000, 1'h0, 32'hC000_0000);
    dec(32'hC000_0004, 1'h1, 4'h0, SP_PERIPH, 32'h4, 1'h1);
    dec(32'hC400_0000, 1'h0, 4'h0, SP_BACKDOOR, 32'h0, 1'h1);
  endtask : defaults_and_map

  task automatic sampled_modes;
    cfg_case(1'h0, 10'h3DA, OPM_MASTER, 2'h1, WIDTH_8, 1'h1, CLK_PLL_EXT, 3'h4);
    dec(32'h0000_0010, 1'h1, 4'h0, SP_NONE, 32'h0, 1'h0);
    cfg_case(1'h0, 10'h345, OPM_SINGLE, 2'h2, WIDTH_32, 1'h0, CLK_PLL_1TO1, 3'h6);
    cfg_case(1'h0, 10'h233, OPM_FACTORY, 2'h1, WIDTH_16, 1'h1, CLK_BYPASS, 3'h7);
    cfg_case(1'h0, 10'h2EC, OPM_RESERVED, 2'h1, WIDTH_32, 1'h0, CLK_PLL_XTAL, 3'h0);
    cfg_case(1'h0, 10'h19C, OPM_RESERVED, 2'h0, WIDTH_32, 1'h1, CLK_PLL_XTAL, 3'h0);
    dec(32'h0000_0010, 1'h1, 4'h0, SP_FLASH, 32'h10, 1'h1);
  endtask : sampled_modes

  initial begin
    rst        = 1'h1;
    en_n       = 1'h1;
    want       = 10'h000;
    bwr        = 3'h0;
    bdata      = '0;
    req        = '0;
    ext_hit    = 4'h0;
    mismatches = 0;
    n_tests    = 0;
    cycles     = 0;
    defaults_and_map();
    sampled_modes();
    tally_and_finish();
  end
endmodule : rcbm_top_test
`default_nettype wire
